// ### rtl/sfs_pkg.sv
package sfs_pkg;

  // Clock and gear switching guard time
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned GEAR_IDLE_NS  = 1000000;
  localparam int unsigned GEAR_IDLE_CYC =
    (GEAR_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] A_BASIC   = 8'h00;
  localparam logic [7:0] A_DIRLIM  = 8'h04;
  localparam logic [7:0] A_GEARENC = 8'h08;
  localparam logic [7:0] A_COMPOVL = 8'h0c;
  localparam logic [7:0] A_MODE    = 8'h10;
  localparam logic [7:0] A_CMD     = 8'h14;
  localparam logic [7:0] A_STATUS  = 8'h18;

  // Reset values of the switch words
  localparam logic [15:0] RST_BASIC   = 16'h0000;
  localparam logic [15:0] RST_DIRLIM  = 16'h0000;
  localparam logic [15:0] RST_GEARENC = 16'h0000;
  localparam logic [15:0] RST_COMPOVL = 16'h0000;
  localparam logic [15:0] RST_MODE    = 16'h0000;

  // Each setting is one hex digit of its word
  localparam int unsigned SON_SRC_POS  = 0;
  localparam int unsigned FOT_EN_POS   = 4;
  localparam int unsigned ROT_EN_POS   = 8;
  localparam int unsigned PLA_POS      = 12;
  localparam int unsigned DIR_POS      = 0;
  localparam int unsigned ASL_POS      = 4;
  localparam int unsigned ATL_POS      = 8;
  localparam int unsigned GEAR2_POS    = 12;
  localparam int unsigned GSW_MODE_POS = 0;
  localparam int unsigned ENC_POS      = 8;
  localparam int unsigned LSC_POS      = 8;
  localparam int unsigned OVL_POS      = 12;
  localparam int unsigned STOP_POS     = 0;
  localparam int unsigned CMODE_POS    = 4;

  // Digit codes
  localparam logic [3:0] CM_SPEED    = 4'h0;
  localparam logic [3:0] CM_POSITION = 4'h1;
  localparam logic [3:0] CM_TORQUE   = 4'h2;
  localparam logic [3:0] ENC_INCR    = 4'h1;

  // Command and status bits
  localparam int unsigned CMD_RESTART = 0;
  localparam int unsigned CMD_FLT_CLR = 1;
  localparam int unsigned ST_READY    = 0;
  localparam int unsigned ST_EXC      = 1;
  localparam int unsigned ST_ALARM    = 2;
  localparam int unsigned ST_FOT      = 3;
  localparam int unsigned ST_ROT      = 4;
  localparam int unsigned ST_GEAR2    = 5;
  localparam int unsigned ST_PCTL     = 6;
  localparam int unsigned ST_ENC_INC  = 7;

  // AHB-Lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  typedef enum logic {SFS_LOAD, SFS_RUN} sfs_state_t;

endpackage

// ### rtl/sfs_sync.sv
`timescale 1ns/10ps
module sfs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // Two stages; only the second stage is visible outside
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// ### rtl/sfs_gear_switch.sv
`timescale 1ns/10ps
module sfs_gear_switch #(
  parameter int unsigned IDLE_CYCLES = 40000
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic gain_sw,
  input  wire logic pulse,
  input  wire logic timing_mode,
  output logic      gear_sel
);

  localparam int unsigned CW = $clog2(IDLE_CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(IDLE_CYCLES);

  logic          pulse_prev_q;
  logic [CW-1:0] idle_q;
  logic [CW-1:0] stable_q;
  logic          sw_prev_q;
  wire           pulse_edge = pulse ^ pulse_prev_q;
  wire           sw_edge    = gain_sw ^ sw_prev_q;
  wire           idle_done  = idle_q >= LIMIT;
  wire           stab_done  = stable_q >= LIMIT;
  // Mode 1 also waits for a quiet time after the input change
  wire           take = idle_done & (~timing_mode | stab_done);

  // Quiet-time counters saturate at the guard time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_prev_q <= 1'b0;
      sw_prev_q    <= 1'b0;
      idle_q       <= '0;
      stable_q     <= '0;
    end else begin
      pulse_prev_q <= pulse;
      sw_prev_q    <= gain_sw;
      idle_q       <= pulse_edge ? '0 : idle_q + CW'(!idle_done);
      stable_q     <= sw_edge ? '0 : stable_q + CW'(!stab_done);
    end
  end

  // Numerator swaps only while the pulse train is idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gear_sel <= 1'b0;
    end else if (take) begin
      gear_sel <= gain_sw;
    end
  end

endmodule

// ### rtl/sfs_top.sv
`timescale 1ns/10ps
// Functional notes
// - Servo-on source 0 obeys servo-on input; 1 excites automatically after ready
// - Forward overtravel bit 0 honours input and requests stop; 1 ignores
// - Reverse overtravel bit 0 honours input and requests stop; 1 ignores
// - Supply loss raises alarm only when power-loss alarm bit is 1
// - Direction bit 0 makes CCW forward, 1 makes CW forward
// - Torque mode speed limit: parameter, or min of analog and parameter
// - Torque limit from parameters, or from analog reference when bit is 1
// - Gear bit 0: gain input picks P/PI; 1: second gear in position
// - Encoder field 0 absolute use, 1 incremental-only use
// - Low-speed bit 1 applies creep correction of the given amount
// - Overload bit 1 enables overload enhancement above twice rated load
module sfs_top
  import sfs_pkg::*;
#(
  parameter int unsigned GEAR_IDLE_CYCLES = GEAR_IDLE_CYC,
  parameter int unsigned VW               = 16
) (
  input  wire logic          CLK,
  input  wire logic          RST_B,
  input  wire logic          HSEL,
  input  wire logic [31:0]   HADDR,
  input  wire logic [1:0]    HTRANS,
  input  wire logic          HWRITE,
  input  wire logic [2:0]    HSIZE,
  input  wire logic [31:0]   HWDATA,
  input  wire logic          HREADY,
  output logic      [31:0]   HRDATA,
  output logic               HREADYOUT,
  output logic               HRESP,
  input  wire logic          SERVO_ON_IN,
  input  wire logic          FWD_OT_IN,
  input  wire logic          REV_OT_IN,
  input  wire logic          GAIN_SW_IN,
  input  wire logic          SUPPLY_LOSS_IN,
  input  wire logic          REF_PULSE_IN,
  input  wire logic          REF_DIR_REV,
  input  wire logic [VW-1:0] ANALOG_SPEED,
  input  wire logic [VW-1:0] SPEED_LIMIT_PARAM,
  input  wire logic [VW-1:0] ANALOG_TREF,
  input  wire logic [VW-1:0] TORQUE_LIMIT_PARAM,
  input  wire logic [VW-1:0] LOW_SPEED_AMOUNT,
  output logic               SERVO_READY,
  output logic               MOTOR_EXCITE,
  output logic               ALARM_OUT,
  output logic               FWD_STOP_REQ,
  output logic               REV_STOP_REQ,
  output logic [3:0]         STOP_MODE,
  output logic               MOTOR_CW,
  output logic [VW-1:0]      SPEED_LIMIT,
  output logic [VW-1:0]      TORQUE_LIMIT,
  output logic               P_CONTROL,
  output logic               SECOND_GEAR,
  output logic               ENC_INCREMENTAL,
  output logic [VW-1:0]      LOW_SPEED_CORR,
  output logic               OVERLOAD_ENH
);

  // Reset release synchroniser
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // Pin inputs cross into the clock domain
  logic son_s;
  logic fot_s;
  logic rot_s;
  logic gsw_s;
  logic loss_s;
  logic pulse_s;

  sfs_sync #(
    .W (6)
  ) u_sync (
    .clk   (CLK),
    .rst_n (rst_n),
    .d     ({SERVO_ON_IN, FWD_OT_IN, REV_OT_IN,
             GAIN_SW_IN, SUPPLY_LOSS_IN, REF_PULSE_IN}),
    .q     ({son_s, fot_s, rot_s, gsw_s, loss_s, pulse_s})
  );

  // AHB-Lite address phase decode
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  wire        addr_ok  = HSEL & HREADY & HTRANS[1];
  wire        rd_req   = addr_ok & ~HWRITE;
  wire        wr_req   = addr_ok & HWRITE;
  wire  [7:0] rd_addr  = HADDR[7:0];
  wire        wr_basic = wr_pend_q & (wr_addr_q == A_BASIC);
  wire        wr_dir   = wr_pend_q & (wr_addr_q == A_DIRLIM);
  wire        wr_gear  = wr_pend_q & (wr_addr_q == A_GEARENC);
  wire        wr_comp  = wr_pend_q & (wr_addr_q == A_COMPOVL);
  wire        wr_mode  = wr_pend_q & (wr_addr_q == A_MODE);
  wire        wr_cmd   = wr_pend_q & (wr_addr_q == A_CMD);
  wire        restart  = wr_cmd & HWDATA[CMD_RESTART];
  wire        flt_clr  = wr_cmd & HWDATA[CMD_FLT_CLR];

  // Address is held for the data phase, where the write lands
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= wr_req;
      wr_addr_q <= rd_addr;
    end
  end

  // Software copies of the switch words
  logic [15:0] sw_basic_q;
  logic [15:0] sw_dir_q;
  logic [15:0] sw_gear_q;
  logic [15:0] sw_comp_q;
  logic [15:0] sw_mode_q;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      sw_basic_q <= RST_BASIC;
      sw_dir_q   <= RST_DIRLIM;
      sw_gear_q  <= RST_GEARENC;
      sw_comp_q  <= RST_COMPOVL;
      sw_mode_q  <= RST_MODE;
    end else begin
      if (wr_basic) sw_basic_q <= HWDATA[15:0];
      if (wr_dir)   sw_dir_q   <= HWDATA[15:0];
      if (wr_gear)  sw_gear_q  <= HWDATA[15:0];
      if (wr_comp)  sw_comp_q  <= HWDATA[15:0];
      if (wr_mode)  sw_mode_q  <= HWDATA[15:0];
    end
  end

  // Applied copies; loaded only at reset release or restart
  sfs_state_t  state_q;
  logic [15:0] cf_basic_q;
  logic [15:0] cf_dir_q;
  logic [15:0] cf_gear_q;
  logic [15:0] cf_comp_q;
  logic [15:0] cf_mode_q;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SFS_LOAD;
    end else begin
      case (state_q)
        SFS_LOAD: state_q <= SFS_RUN;
        SFS_RUN:  state_q <= restart ? SFS_LOAD : SFS_RUN;
        default:  state_q <= SFS_LOAD;
      endcase
    end
  end

  // A write while running waits here until the next restart
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cf_basic_q <= RST_BASIC;
      cf_dir_q   <= RST_DIRLIM;
      cf_gear_q  <= RST_GEARENC;
      cf_comp_q  <= RST_COMPOVL;
      cf_mode_q  <= RST_MODE;
    end else if (state_q == SFS_LOAD) begin
      cf_basic_q <= sw_basic_q;
      cf_dir_q   <= sw_dir_q;
      cf_gear_q  <= sw_gear_q;
      cf_comp_q  <= sw_comp_q;
      cf_mode_q  <= sw_mode_q;
    end
  end

  // Applied settings
  wire       son_auto = cf_basic_q[SON_SRC_POS];
  wire       fot_off  = cf_basic_q[FOT_EN_POS];
  wire       rot_off  = cf_basic_q[ROT_EN_POS];
  wire       pla_on   = cf_basic_q[PLA_POS];
  wire       fwd_cw   = cf_dir_q[DIR_POS];
  wire       asl_on   = cf_dir_q[ASL_POS];
  wire       atl_on   = cf_dir_q[ATL_POS];
  wire       gear2_en = cf_dir_q[GEAR2_POS];
  wire       gsw_mode = cf_gear_q[GSW_MODE_POS];
  wire [3:0] enc_fld  = cf_gear_q[ENC_POS +: 4];
  wire       lsc_on   = cf_comp_q[LSC_POS];
  wire       ovl_on   = cf_comp_q[OVL_POS];
  wire [3:0] stop_fld = cf_mode_q[STOP_POS +: 4];
  wire [3:0] cmode    = cf_mode_q[CMODE_POS +: 4];
  wire       m_pos    = cmode == CM_POSITION;
  wire       m_trq    = cmode == CM_TORQUE;
  wire       m_spd    = cmode == CM_SPEED;

  // Gear numerator select with pulse-idle guard
  logic gear_sel;

  sfs_gear_switch #(
    .IDLE_CYCLES (GEAR_IDLE_CYCLES)
  ) u_gear (
    .clk         (CLK),
    .rst_n       (rst_n),
    .gain_sw     (gsw_s),
    .pulse       (pulse_s),
    .timing_mode (gsw_mode),
    .gear_sel    (gear_sel)
  );

  // Supply loss: one event per rising edge of the loss level
  logic loss_prev_q;
  wire  loss_evt = loss_s & ~loss_prev_q;
  wire  flt_set  = loss_evt & pla_on;

  // Set wins over a clear in the same cycle
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      loss_prev_q <= 1'b0;
      ALARM_OUT   <= 1'b0;
    end else begin
      loss_prev_q <= loss_s;
      ALARM_OUT   <= flt_set | (ALARM_OUT & ~flt_clr);
    end
  end

  // Next values of the drive outputs
  wire          ready_d  = (state_q == SFS_RUN) & ~ALARM_OUT;
  wire          exc_d    = SERVO_READY & ~ALARM_OUT
                           & (son_auto | son_s);
  wire          fstop_d  = ~fot_off & fot_s;
  wire          rstop_d  = ~rot_off & rot_s;
  wire          cw_d     = fwd_cw ^ REF_DIR_REV;
  wire [VW-1:0] spd_min  = (ANALOG_SPEED < SPEED_LIMIT_PARAM) ?
                           ANALOG_SPEED : SPEED_LIMIT_PARAM;
  wire [VW-1:0] spd_d    = (m_trq & asl_on) ?
                           spd_min : SPEED_LIMIT_PARAM;
  wire [VW-1:0] trq_d    = atl_on ?
                           ANALOG_TREF : TORQUE_LIMIT_PARAM;
  // Gain input is ignored in torque control
  wire          pctl_d   = ~gear2_en & gsw_s & (m_spd | m_pos);
  wire          gear2_d  = gear2_en & m_pos & gear_sel;
  wire          enc_d    = enc_fld == ENC_INCR;
  wire [VW-1:0] lsc_d    = lsc_on ? LOW_SPEED_AMOUNT : '0;

  // Registered drive outputs
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      SERVO_READY     <= 1'b0;
      MOTOR_EXCITE    <= 1'b0;
      FWD_STOP_REQ    <= 1'b0;
      REV_STOP_REQ    <= 1'b0;
      STOP_MODE       <= 4'h0;
      MOTOR_CW        <= 1'b0;
      SPEED_LIMIT     <= '0;
      TORQUE_LIMIT    <= '0;
      P_CONTROL       <= 1'b0;
      SECOND_GEAR     <= 1'b0;
      ENC_INCREMENTAL <= 1'b0;
      LOW_SPEED_CORR  <= '0;
      OVERLOAD_ENH    <= 1'b0;
    end else begin
      SERVO_READY     <= ready_d;
      MOTOR_EXCITE    <= exc_d;
      FWD_STOP_REQ    <= fstop_d;
      REV_STOP_REQ    <= rstop_d;
      STOP_MODE       <= stop_fld;
      MOTOR_CW        <= cw_d;
      SPEED_LIMIT     <= spd_d;
      TORQUE_LIMIT    <= trq_d;
      P_CONTROL       <= pctl_d;
      SECOND_GEAR     <= gear2_d;
      ENC_INCREMENTAL <= enc_d;
      LOW_SPEED_CORR  <= lsc_d;
      OVERLOAD_ENH    <= ovl_on;
    end
  end

  // Status word shows the live drive state
  logic [31:0] status;

  always_comb begin
    status              = 32'h0000_0000;
    status[ST_READY]    = SERVO_READY;
    status[ST_EXC]      = MOTOR_EXCITE;
    status[ST_ALARM]    = ALARM_OUT;
    status[ST_FOT]      = FWD_STOP_REQ;
    status[ST_ROT]      = REV_STOP_REQ;
    status[ST_GEAR2]    = SECOND_GEAR;
    status[ST_PCTL]     = P_CONTROL;
    status[ST_ENC_INC]  = ENC_INCREMENTAL;
  end

  // Read mux; unmapped and command addresses read zero
  wire [31:0] rd_data =
    (rd_addr == A_BASIC)   ? {16'h0000, sw_basic_q} :
    (rd_addr == A_DIRLIM)  ? {16'h0000, sw_dir_q}   :
    (rd_addr == A_GEARENC) ? {16'h0000, sw_gear_q}  :
    (rd_addr == A_COMPOVL) ? {16'h0000, sw_comp_q}  :
    (rd_addr == A_MODE)    ? {16'h0000, sw_mode_q}  :
    (rd_addr == A_STATUS)  ? status : 32'h0000_0000;

  // Zero wait states: read data is captured in the address phase
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= HRESP_OKAY;
    end else begin
      HRDATA    <= rd_req ? rd_data : 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= HRESP_OKAY;
    end
  end

endmodule

// ### bench/sfs_asserts.sv
`timescale 1ns/10ps
module sfs_asserts #(
  parameter int unsigned GEAR_IDLE_CYCLES = 20,
  parameter int unsigned VW               = 16
) (
  input wire logic          CLK,
  input wire logic          RST_B,
  input wire logic          HSEL,
  input wire logic [1:0]    HTRANS,
  input wire logic          HREADY,
  input wire logic [31:0]   HRDATA,
  input wire logic          HREADYOUT,
  input wire logic          HRESP,
  input wire logic          SUPPLY_LOSS_IN,
  input wire logic          FWD_OT_IN,
  input wire logic          REF_PULSE_IN,
  input wire logic [VW-1:0] SPEED_LIMIT_PARAM,
  input wire logic          SERVO_READY,
  input wire logic          MOTOR_EXCITE,
  input wire logic          ALARM_OUT,
  input wire logic          FWD_STOP_REQ,
  input wire logic [VW-1:0] SPEED_LIMIT,
  input wire logic          SECOND_GEAR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);

  // Raw quiet time on the pulse pin; the design sees it later, never sooner
  logic [15:0] idle_q;
  logic        pulse_q;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      idle_q  <= 16'h0000;
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= REF_PULSE_IN;
      if (REF_PULSE_IN != pulse_q)
        idle_q <= 16'h0000;
      else if (idle_q != 16'hffff)
        idle_q <= idle_q + 16'h0001;
    end
  end

  a_bus_okay: assert property (
    HRESP == 1'b0 && HREADYOUT == 1'b1 && HRDATA[31:16] == 16'h0000)
    else $error("bus response not okay");
  a_rdata_idle: assert property (
    !(HSEL && HREADY && HTRANS[1]) |=> HRDATA == 32'h00000000)
    else $error("read data outside data phase");
  a_excite_ready: assert property (
    $rose(MOTOR_EXCITE) |-> SERVO_READY)
    else $error("excite without ready");
  a_alarm_blocks: assert property (
    ALARM_OUT ##1 ALARM_OUT |-> !SERVO_READY && !MOTOR_EXCITE)
    else $error("alarm did not drop ready");
  a_alarm_cause: assert property (
    $rose(ALARM_OUT) |-> $past(SUPPLY_LOSS_IN, 2))
    else $error("alarm without supply loss");
  a_fwd_cause: assert property (
    $rose(FWD_STOP_REQ) |-> $past(FWD_OT_IN, 2))
    else $error("stop request without overtravel");
  a_speed_bound: assert property (
    $stable(SPEED_LIMIT_PARAM) [*2] |-> SPEED_LIMIT <= SPEED_LIMIT_PARAM)
    else $error("speed limit above parameter");
  a_gear_quiet: assert property (
    $rose(SECOND_GEAR) |-> int'(idle_q) >= GEAR_IDLE_CYCLES)
    else $error("gear switched while pulses ran");
endmodule

bind sfs_top sfs_asserts #(
  .GEAR_IDLE_CYCLES(GEAR_IDLE_CYCLES),
  .VW(VW)
) u_asserts (
  .CLK, .RST_B, .HSEL, .HTRANS, .HREADY, .HRDATA, .HREADYOUT, .HRESP,
  .SUPPLY_LOSS_IN, .FWD_OT_IN, .REF_PULSE_IN, .SPEED_LIMIT_PARAM,
  .SERVO_READY, .MOTOR_EXCITE, .ALARM_OUT, .FWD_STOP_REQ, .SPEED_LIMIT,
  .SECOND_GEAR
);

// ### bench/sfs_ctrl_model.sv
`timescale 1ns/10ps
module sfs_ctrl_model #(
  parameter int unsigned IDLE = 30
) (
  input  wire logic clk,
  input  wire logic run,
  input  wire logic gain_req,
  input  wire logic rude,
  output logic      pulse,
  output logic      gain_sw
);
  int   quiet = 0;
  logic post  = 1'b0;
  initial pulse = 1'b0;
  initial gain_sw = 1'b0;
  // Pulses pause around each gain change; rude skips both pauses
  always @(posedge clk) begin
    if (gain_req != gain_sw) begin
      if (rude || quiet > IDLE) begin
        gain_sw <= gain_req;
        quiet   <= 0;
        post    <= !rude;
      end else begin
        quiet <= quiet + 1;
      end
    end else if (post && quiet <= IDLE) begin
      quiet <= quiet + 1;
    end else begin
      post <= 1'b0;
      quiet <= run ? 0 : quiet + 1;
      if (run)
        pulse <= ~pulse;
    end
  end
endmodule

// ### bench/testbench.sv
`timescale 1ns/10ps
module testbench;
  import sfs_pkg::*;
  logic CLK = 0, RST_B = 0, HSEL = 0, HWRITE = 0;
  logic [1:0] HTRANS = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, rd;
  logic HREADYOUT, HRESP, SERVO_READY, MOTOR_EXCITE, ALARM_OUT;
  logic FWD_STOP_REQ, REV_STOP_REQ, MOTOR_CW, P_CONTROL, SECOND_GEAR;
  logic ENC_INCREMENTAL, OVERLOAD_ENH, gsw, pulse;
  logic SERVO_ON_IN = 0, FWD_OT_IN = 0, REV_OT_IN = 0, SUPPLY_LOSS_IN = 0;
  logic REF_DIR_REV = 0, run = 0, greq = 0, rude = 0;
  logic [3:0] STOP_MODE;
  logic [15:0] ANALOG_SPEED = 0, SPEED_LIMIT_PARAM = 0, ANALOG_TREF = 0;
  logic [15:0] TORQUE_LIMIT_PARAM = 0, LOW_SPEED_AMOUNT = 0;
  logic [15:0] SPEED_LIMIT, TORQUE_LIMIT, LOW_SPEED_CORR;
  int n_fail = 0, n_compared = 0, seed = 93377;
  int cfg[5] = '{0, 0, 0, 0, 0};
  int wr[5];
  wire HREADY = HREADYOUT;

  always #12.5 CLK = ~CLK;

  sfs_top #(.GEAR_IDLE_CYCLES(20), .VW(16)) u_dut (
    .CLK, .RST_B, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA,
    .HREADY, .HRDATA, .HREADYOUT, .HRESP, .SERVO_ON_IN, .FWD_OT_IN,
    .REV_OT_IN, .GAIN_SW_IN(gsw), .SUPPLY_LOSS_IN, .REF_PULSE_IN(pulse),
    .REF_DIR_REV, .ANALOG_SPEED, .SPEED_LIMIT_PARAM, .ANALOG_TREF,
    .TORQUE_LIMIT_PARAM, .LOW_SPEED_AMOUNT, .SERVO_READY, .MOTOR_EXCITE,
    .ALARM_OUT, .FWD_STOP_REQ, .REV_STOP_REQ, .STOP_MODE, .MOTOR_CW,
    .SPEED_LIMIT, .TORQUE_LIMIT, .P_CONTROL, .SECOND_GEAR,
    .ENC_INCREMENTAL, .LOW_SPEED_CORR, .OVERLOAD_ENH);

  sfs_ctrl_model #(.IDLE(30)) u_ctrl (
    .clk(CLK), .run, .gain_req(greq), .rude, .pulse, .gain_sw(gsw));

  task automatic waitc(input int n);
    repeat (n) @(posedge CLK);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One single transfer; read data is taken at the closing edge
  task automatic bus(input logic w, input int a, input int d,
                     output logic [31:0] r);
    HSEL <= 1'b1;
    HADDR <= 32'(a);
    HTRANS <= HTRANS_NONSEQ;
    HWRITE <= w;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= 32'(d);
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    r = HRDATA;
  endtask

  task automatic write_all;
    for (int i = 0; i < 5; i++)
      bus(1, 4 * i, wr[i], rd);
  endtask

  // Switch words only take hold through a restart
  task automatic restart;
    bus(1, A_CMD, 1, rd);
    cfg = wr;
    waitc(50);
  endtask

  task automatic check_outs;
    int m;
    m = cfg[4][7:4];
    chk(MOTOR_EXCITE, cfg[0][0] ? 1 : SERVO_ON_IN, "excite");
    chk(FWD_STOP_REQ, cfg[0][4] ? 0 : FWD_OT_IN, "fwd stop");
    chk(REV_STOP_REQ, cfg[0][8] ? 0 : REV_OT_IN, "rev stop");
    chk(MOTOR_CW, cfg[1][0] ^ REF_DIR_REV, "cw");
    chk(SPEED_LIMIT, (m == 2 && cfg[1][4] && ANALOG_SPEED <
        SPEED_LIMIT_PARAM) ? ANALOG_SPEED : SPEED_LIMIT_PARAM, "spd");
    chk(TORQUE_LIMIT, cfg[1][8] ? ANALOG_TREF : TORQUE_LIMIT_PARAM,
        "trq");
    chk(P_CONTROL, !cfg[1][12] && m != 2 && gsw, "p control");
    chk(SECOND_GEAR, cfg[1][12] && m == 1 && gsw, "gear");
    chk(ENC_INCREMENTAL, cfg[2][8], "enc");
    chk(LOW_SPEED_CORR, cfg[3][8] ? LOW_SPEED_AMOUNT : 0, "corr");
    chk(OVERLOAD_ENH, cfg[3][12], "ovl");
    chk(STOP_MODE, cfg[4][3:0], "stop mode");
  endtask

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard, far beyond the roughly 1700 cycles the tests need
  initial begin
    waitc(30000);
    n_fail++;
    $display("mismatch t=%0t timeout", $time);
    end_sim;
  end

  initial begin
    waitc(5);
    RST_B <= 1'b1;
    waitc(6);
    for (int i = 0; i < 5; i++) begin
      bus(0, 4 * i, 0, rd);
      chk(rd, 0, "reset word");
    end
    bus(1, 32'h20, 32'h1111, rd);
    bus(0, 32'h20, 0, rd);
    chk(rd, 0, "unmapped");
    bus(0, A_CMD, 0, rd);
    chk(rd, 0, "cmd read");
    bus(0, A_STATUS, 0, rd);
    chk(rd[ST_READY], 1, "ready");
    $display("test reset done");
    // Random words: no effect before restart, full effect after
    for (int k = 0; k < 6; k++) begin
      wr[0] = $random(seed) & 32'h1111;
      wr[1] = $random(seed) & 32'h1111;
      wr[2] = $random(seed) & 32'h0101;
      wr[3] = $random(seed) & 32'h1100;
      wr[4] = ({$random(seed)} % 6) | (({$random(seed)} % 3) << 4);
      {SERVO_ON_IN, FWD_OT_IN, REV_OT_IN, REF_DIR_REV, greq} <=
        5'($random(seed));
      ANALOG_SPEED <= 16'($random(seed));
      SPEED_LIMIT_PARAM <= 16'($random(seed));
      ANALOG_TREF <= 16'($random(seed));
      TORQUE_LIMIT_PARAM <= 16'($random(seed));
      LOW_SPEED_AMOUNT <= 16'($random(seed));
      write_all;
      for (int i = 0; i < 5; i++) begin
        bus(0, 4 * i, 0, rd);
        chk(rd, wr[i], "readback");
      end
      waitc(50);
      check_outs;
      restart;
      check_outs;
    end
    $display("test config done");
    // Supply loss with the alarm bit off and on
    for (int p = 0; p < 2; p++) begin
      wr = '{p << 12, 0, 0, 0, 0};
      write_all;
      restart;
      SUPPLY_LOSS_IN <= 1'b1;
      waitc(6);
      SUPPLY_LOSS_IN <= 1'b0;
      waitc(4);
      chk(ALARM_OUT, p, "alarm");
      chk(SERVO_READY, p == 0, "ready");
      bus(1, A_CMD, 2, rd);
      waitc(4);
      chk(ALARM_OUT, 0, "alarm clear");
    end
    $display("test alarm done");
    // Gear switch with a polite and then a rude controller
    for (int t = 0; t < 2; t++) begin
      greq <= 1'b0;
      waitc(80);
      wr = '{0, 32'h1000, t, 0, 32'h10};
      write_all;
      restart;
      run <= 1'b1;
      waitc(20);
      greq <= 1'b1;
      waitc(100);
      chk(SECOND_GEAR, 1, "gear polite");
      rude <= 1'b1;
      greq <= 1'b0;
      waitc(60);
      chk(SECOND_GEAR, 1, "gear held");
      run <= 1'b0;
      waitc(60);
      chk(SECOND_GEAR, 0, "gear late");
      rude <= 1'b0;
    end
    $display("test gear done");
    // Mid-run reset brings every word back to its reset value
    RST_B <= 1'b0;
    waitc(5);
    RST_B <= 1'b1;
    waitc(6);
    cfg = '{0, 0, 0, 0, 0};
    for (int i = 0; i < 5; i++) begin
      bus(0, 4 * i, 0, rd);
      chk(rd, 0, "word after reset");
    end
    check_outs;
    $display("test second reset done");
    end_sim;
  end
endmodule
